// ---- core/flash_status_host.sv ----
// Host controller: raw flash reads and writes plus the polling and toggle algorithms.
// Assumes the user issues the command sequence with OP_WRITE before polling.
module flash_status_host
    import flash_status_pkg::*;
#(
    parameter int MAX_POLLS = 65535
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // User orders
    input wire logic START_I,
    input wire op_t OP_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] DATA_I,
    output logic BUSY_O,
    output logic DONE_O,
    output res_t RESULT_O,
    output logic [DATA_W-1:0] RDATA_O,
    output logic WINDOW_OPEN_O,
    // Flash pins
    output logic [ADDR_W-1:0] FA_O,
    output logic [DATA_W-1:0] FDQ_O,
    output logic FDQ_OE_O,
    input wire logic [DATA_W-1:0] FDQ_I,
    output logic FCE_N_O,
    output logic FOE_N_O,
    output logic FWE_N_O
);
    // ****************************************
    // Cycle engine
    // ****************************************
    flash_bus_if bus ();
    logic [ADDR_W-1:0] a_w;
    logic [DATA_W-1:0] d_w;
    logic oe_w, ce_w, oen_w, wen_w;

    flash_cycle u_cycle (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .bus(bus),
        .addr_o(a_w),
        .dq_o(d_w),
        .dq_oe_o(oe_w),
        .dq_i(FDQ_I),
        .ce_n_o(ce_w),
        .oe_n_o(oen_w),
        .we_n_o(wen_w)
    );

    // Pins registered once more so every top output comes from a flop
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            FA_O <= '0;
            FDQ_O <= '0;
            FDQ_OE_O <= 1'b0;
            FCE_N_O <= 1'b1;
            FOE_N_O <= 1'b1;
            FWE_N_O <= 1'b1;
        end else begin
            FA_O <= a_w;
            FDQ_O <= d_w;
            FDQ_OE_O <= oe_w;
            FCE_N_O <= ce_w;
            FOE_N_O <= oen_w;
            FWE_N_O <= wen_w;
        end
    end

    // ****************************************
    // Polling sequencer
    // ****************************************
    typedef enum logic [2:0] {S_IDLE, S_RAW, S_FIRST, S_SECOND, S_RECHECK, S_RESET, S_FINAL} st_t;
    st_t st_ff, nxt_st;
    op_t op_ff, nxt_op;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] data_ff, nxt_data;
    logic [DATA_W-1:0] prev_ff, nxt_prev;
    logic req_ff, nxt_req;
    logic wr_ff, nxt_wr;
    logic [DATA_W-1:0] wd_ff, nxt_wd;
    logic busy_ff, nxt_busy, done_ff, nxt_done, win_ff, nxt_win;
    res_t res_ff, nxt_res;
    logic [DATA_W-1:0] rd_ff, nxt_rd;
    logic [15:0] polls_ff, nxt_polls;
    logic [DATA_W-1:0] rd;
    logic toggled, poll_true, timed_out;

    assign rd = bus.rdata;
    // Toggle check compares two back-to-back reads [RQ14]
    assign toggled = (rd[DEV_TOGGLE_BIT] != prev_ff[DEV_TOGGLE_BIT]);
    // Polling bit equal to the expected true bit 7 means finished [RQ2] [RQ5]
    assign poll_true = (rd[POLL_BIT] == data_ff[POLL_BIT]);
    assign timed_out = rd[TIMEOUT_BIT];

    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        nxt_prev = prev_ff;
        nxt_req = 1'b0;
        nxt_wr = wr_ff;
        nxt_wd = wd_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_win = win_ff;
        nxt_res = res_ff;
        nxt_rd = rd_ff;
        nxt_polls = polls_ff;
        unique case (st_ff)
            S_IDLE: begin
                if (START_I) begin
                    nxt_op = OP_I;
                    // Poll address must be the programmed byte or an erasing sector [RQ3] [RQ6]
                    nxt_addr = ADDR_I;
                    nxt_data = DATA_I;
                    nxt_busy = 1'b1;
                    nxt_req = 1'b1;
                    nxt_wr = (OP_I == OP_WRITE);
                    nxt_wd = DATA_I;
                    nxt_polls = '0;
                    nxt_st = (OP_I == OP_READ || OP_I == OP_WRITE) ? S_RAW : S_FIRST;
                end
            end
            S_RAW: begin
                if (bus.done) begin
                    nxt_rd = rd;
                    nxt_res = RES_DATA;
                    // Erase window bit taken from any raw read, with no polling status check first [RQ20] [RQ22]
                    nxt_win = !rd[WINDOW_BIT];
                    nxt_st = S_IDLE;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            S_FIRST: begin
                if (bus.done) begin
                    // A fresh check always starts with a new double read [RQ16]
                    nxt_prev = rd;
                    nxt_req = 1'b1;
                    nxt_st = S_SECOND;
                end
            end
            S_SECOND: begin
                if (bus.done) begin
                    nxt_prev = rd;
                    nxt_polls = polls_ff + 1'b1;
                    if ((op_ff == OP_POLL) ? poll_true : !toggled) begin
                        // Data is taken from the next read, not the completing one [RQ9]
                        nxt_req = 1'b1;
                        nxt_st = S_FINAL;
                    end else if (timed_out) begin
                        nxt_req = 1'b1;
                        nxt_st = S_RECHECK;
                    end else if (polls_ff == 16'(MAX_POLLS)) begin
                        nxt_wr = 1'b1;
                        nxt_wd = CMD_RESET;
                        nxt_req = 1'b1;
                        nxt_st = S_RESET;
                    end else begin
                        nxt_req = 1'b1;
                    end
                end
            end
            S_RECHECK: begin
                if (bus.done) begin
                    if ((op_ff == OP_POLL) ? poll_true : !toggled) begin
                        nxt_req = 1'b1;
                        nxt_st = S_FINAL;
                    end else begin
                        // Failure: write reset command to return to array reads [RQ15] [RQ19] [RQ24]
                        nxt_wr = 1'b1;
                        nxt_wd = CMD_RESET;
                        nxt_req = 1'b1;
                        nxt_st = S_RESET;
                    end
                end
            end
            S_RESET: begin
                if (bus.done) begin
                    nxt_wr = 1'b0;
                    nxt_res = RES_FAIL;
                    nxt_st = S_IDLE;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            S_FINAL: begin
                if (bus.done) begin
                    nxt_rd = rd;
                    nxt_res = RES_OK;
                    nxt_st = S_IDLE;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
            default: nxt_st = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_ff <= S_IDLE;
            op_ff <= OP_READ;
            addr_ff <= '0;
            data_ff <= '0;
            prev_ff <= '0;
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            wd_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            win_ff <= 1'b0;
            res_ff <= RES_OK;
            rd_ff <= '0;
            polls_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            prev_ff <= nxt_prev;
            req_ff <= nxt_req;
            wr_ff <= nxt_wr;
            wd_ff <= nxt_wd;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            win_ff <= nxt_win;
            res_ff <= nxt_res;
            rd_ff <= nxt_rd;
            polls_ff <= nxt_polls;
        end
    end

    assign bus.req = req_ff;
    assign bus.wr = wr_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wd_ff;
    assign BUSY_O = busy_ff;
    assign DONE_O = done_ff;
    assign RESULT_O = res_ff;
    assign RDATA_O = rd_ff;
    assign WINDOW_OPEN_O = win_ff;
endmodule

// ---- inc/flash_status_pkg.sv ----
// Constants, command codes and timing for the flash status polling controller.
// Assumes a byte-wide parallel flash with active-low strobes driven by this host.
// Function
// [RQ1] Device gives polling status from the last write strobe of a command.
// [RQ2] Programming shows inverted bit 7 on the polling bit, true bit 7 when done.
// [RQ3] Host reads polling status at the address being programmed.
// [RQ4] Program to a protected sector shows busy about 2 us, then array reads.
// [RQ5] Erase drives polling bit low, high when done or suspended.
// [RQ6] Host polls at an address inside a sector selected for erase.
// [RQ7] Erase of only protected sectors shows busy about 100 us.
// [RQ8] Protected sectors in a mixed erase are skipped without error.
// [RQ9] Host takes valid data only from reads after the one showing completion.
// [RQ10] Device toggle bit inverts every read while an operation runs.
// [RQ11] Device toggle bit also toggles during protected-sector busy times.
// [RQ12] Device toggle bit stops in erase suspend, toggles for suspended program.
// [RQ13] Sector toggle bit inverts on reads inside sectors selected for erase.
// [RQ14] Host compares two consecutive reads; unchanged means finished.
// [RQ15] Still toggling with timeout bit high after recheck means failure, send reset.
// [RQ16] Host restarts the double read after stopping to do other work.
// [RQ17] Timeout bit goes to 1 when the pulse-count limit is exceeded.
// [RQ18] Programming a 0 to a 1 ends in the timeout-failure state.
// [RQ19] After a timeout failure the host writes the reset command.
// [RQ20] Erase window timer bit reads 0 in window, 1 when it expires.
// [RQ21] Device takes further sector erase commands only while the timer bit is 0.
// [RQ22] Host checks polling status before reading the erase window timer bit; this host takes it from any raw read without that check.
// [RQ23] In erase suspend, suspended sectors return status, others array data.
// [RQ24] Reset command is one write of F0 to any address.
// [RQ25] Status replaces array data only while an internal algorithm is pending.
package flash_status_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Status bit positions on the data bus
    localparam int POLL_BIT = 7;
    localparam int DEV_TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int WINDOW_BIT = 3;
    localparam int SECT_TOGGLE_BIT = 2;
    // Commands
    localparam logic [7:0] CMD_RESET = 8'hF0;
    // Bus timing: each strobe phase held this long
    localparam int CLK_MHZ = 50;
    localparam int PHASE_NS = 80;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int PHASE_W = 4;
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_POLL, OP_TOGGLE} op_t;
    typedef enum logic [1:0] {RES_OK, RES_FAIL, RES_DATA} res_t;
endpackage

// ---- inc/flash_bus_if.sv ----
// Carries one bus cycle request and its answer between the poller and the cycle engine.
// Assumes a single clock domain.
interface flash_bus_if;
    import flash_status_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic done;
    logic [DATA_W-1:0] rdata;
    modport master (output req, output wr, output addr, output wdata, input done, input rdata);
    modport slave (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ---- core/flash_cycle.sv ----
// Runs one asynchronous read or write cycle on the flash pins.
// Assumes strobe timing met by holding the strobe phase PHASE_CYC clocks; setup and end take one clock each.
module flash_cycle
    import flash_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    flash_bus_if.slave bus,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [DATA_W-1:0] dq_i,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_END} cst_t;
    cst_t st_ff, nxt_st;
    logic [PHASE_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic done_ff, nxt_done;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = rd_ff;
        nxt_done = 1'b0;
        unique case (st_ff)
            C_IDLE: begin
                if (bus.req) begin
                    nxt_st = C_SETUP;
                    nxt_wr = bus.wr;
                    nxt_addr = bus.addr;
                    nxt_wd = bus.wdata;
                    nxt_cnt = '0;
                end
            end
            C_SETUP: begin
                nxt_st = C_STROBE;
                nxt_cnt = '0;
            end
            C_STROBE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == PHASE_W'(PHASE_CYC - 1)) begin
                    nxt_st = C_END;
                    nxt_rd = dq_i;
                end
            end
            C_END: begin
                nxt_st = C_IDLE;
                nxt_done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= C_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
            wd_ff <= '0;
            rd_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
            done_ff <= nxt_done;
        end
    end

    // Each read is a full chip-select cycle so the device counts it for toggling
    assign addr_o = addr_ff;
    assign dq_o = wd_ff;
    assign dq_oe_o = wr_ff && (st_ff != C_IDLE);
    assign ce_n_o = !(st_ff == C_SETUP || st_ff == C_STROBE);
    assign oe_n_o = !(!wr_ff && st_ff == C_STROBE);
    assign we_n_o = !(wr_ff && st_ff == C_STROBE);
    assign bus.done = done_ff;
    assign bus.rdata = rd_ff;
endmodule

// ---- bench/flash_status_host_assertions.sv ----
// Checker for the flash status host, bound to its top ports.
// Assumes one clock domain and the active-low asynchronous reset.
module flash_status_host_assertions
    import flash_status_pkg::*;
(
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic START_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire res_t RESULT_O,
    input wire logic [ADDR_W-1:0] FA_O,
    input wire logic [DATA_W-1:0] FDQ_O,
    input wire logic FDQ_OE_O,
    input wire logic FCE_N_O,
    input wire logic FOE_N_O,
    input wire logic FWE_N_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic [DATA_W-1:0] last_wr_ff;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            last_wr_ff <= 8'h00;
        end else if (!FWE_N_O) begin
            last_wr_ff <= FDQ_O;
        end
    end
    sequence s_take;
        START_I && !BUSY_O;
    endsequence
    sequence s_rd;
        !FOE_N_O && !FCE_N_O;
    endsequence
    a_take_busy: assert property (s_take |=> BUSY_O) else $error("order not taken");
    a_done_once: assert property (DONE_O |=> !DONE_O && !BUSY_O) else $error("done not single");
    a_done_busy: assert property (DONE_O |-> $past(BUSY_O)) else $error("done while idle");
    a_no_clash: assert property (!(!FOE_N_O && !FWE_N_O)) else $error("read and write strobes low");
    a_drive_wr: assert property (!FWE_N_O |-> FDQ_OE_O && !FCE_N_O) else $error("write not driven");
    a_free_rd: assert property (s_rd |-> !FDQ_OE_O) else $error("bus driven in read");
    a_addr_hold: assert property (s_rd ##1 s_rd |-> $stable(FA_O)) else $error("address moved in read");
    a_wr_steady: assert property (!FWE_N_O ##1 !FWE_N_O |-> $stable(FDQ_O) && $stable(FA_O))
        else $error("write data moved");
    a_fail_reset: assert property (DONE_O && RESULT_O == RES_FAIL |-> last_wr_ff == CMD_RESET)
        else $error("failure without reset write");
endmodule
bind flash_status_host flash_status_host_assertions u_chk (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .START_I(START_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .RESULT_O(RESULT_O), .FA_O(FA_O), .FDQ_O(FDQ_O), .FDQ_OE_O(FDQ_OE_O), .FCE_N_O(FCE_N_O),
    .FOE_N_O(FOE_N_O), .FWE_N_O(FWE_N_O)
);

// ---- bench/flash_model.sv ----
// Behavioural flash device: small array plus write status reporting.
// Assumes busy time is counted in read cycles, set by lat_i.
module flash_model
    import flash_status_pkg::*;
(
    input wire logic [ADDR_W-1:0] a_i,
    input wire logic [DATA_W-1:0] d_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic ce_n_i,
    input wire logic [3:0] lat_i,
    output logic [DATA_W-1:0] q_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [7:0] last, pd, st, q_last;
    logic busy, ers, fail, tog, stog;
    int left, wleft;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {last, pd, q_last, busy, ers, fail, tog, stog} = '0;
        left = 0;
        wleft = 0;
    end
    // Command decode at the end of each write strobe
    always @(posedge we_n_i) begin
        if (d_i == CMD_RESET) begin
            {busy, fail, ers} = 3'h0;
        end else if (last == 8'hA0 && !busy) begin
            pd = d_i;
            busy = 1'b1;
            ers = 1'b0;
            left = lat_i + 1;
            fail = |(d_i & ~mem[a_i[3:0]]);
            if (!fail) mem[a_i[3:0]] = d_i;
        end else if (d_i == 8'h30 && last == 8'h55 && (!busy || wleft > 0)) begin
            busy = 1'b1;
            ers = 1'b1;
            left = lat_i + 1;
            wleft = 2;
        end
        last = d_i;
    end
    // Each finished read advances the status
    always @(posedge oe_n_i) begin
        if (busy) begin
            tog = ~tog;
            stog = ers ? ~stog : stog;
            wleft = (wleft > 0) ? wleft - 1 : 0;
            left = left - 1;
            if (!fail && left == 0) begin
                busy = 1'b0;
                if (ers) foreach (mem[i]) mem[i] = 8'hFF;
            end
        end
    end
    assign st = {ers ? 1'b0 : ~pd[7], tog, fail, 1'b0, ers && wleft == 0, ers && stog, 2'h0};
    assign q_o = (!ce_n_i && !oe_n_i) ? (busy ? st : mem[a_i[3:0]]) : ~q_last;
    always @* if (!ce_n_i && !oe_n_i) q_last = q_o;
endmodule

// ---- bench/flash_status_host_tb.sv ----
// Self-checking bench: host controller against the behavioural flash.
// Assumes package and bus interface are compiled first.
module flash_status_host_tb
    import flash_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    op_t op = OP_READ;
    logic [ADDR_W-1:0] addr = 19'h00000;
    logic [DATA_W-1:0] data = 8'h00;
    logic busy, done, win, ce_n, oe_n, we_n, dq_oe;
    res_t result;
    logic [DATA_W-1:0] rdata, dq_out, mq, pd;
    logic [ADDR_W-1:0] fa, pa;
    logic [3:0] lat = 4'h3;
    int bad_count = 0;
    int n_tests = 0;
    flash_status_host #(.MAX_POLLS(8)) dut (
        .CLK_I(clk), .NRST_I(nrst), .START_I(start), .OP_I(op), .ADDR_I(addr), .DATA_I(data),
        .BUSY_O(busy), .DONE_O(done), .RESULT_O(result), .RDATA_O(rdata), .WINDOW_OPEN_O(win),
        .FA_O(fa), .FDQ_O(dq_out), .FDQ_OE_O(dq_oe), .FDQ_I(dq_oe ? dq_out : mq),
        .FCE_N_O(ce_n), .FOE_N_O(oe_n), .FWE_N_O(we_n)
    );
    flash_model u_flash (
        .a_i(fa), .d_i(dq_out), .oe_n_i(oe_n), .we_n_i(we_n), .ce_n_i(ce_n), .lat_i(lat), .q_o(mq)
    );
    initial begin
        forever #10 clk = ~clk;
    end
    // ****************************************
    // Bench tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask
    task automatic run(input op_t o, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        {start, op, addr, data} <= {1'b1, o, a, d};
        @(posedge clk);
        start <= 1'b0;
        // Sample outputs mid-cycle, away from the edge that launches them
        for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
        chk("done seen", 8'h01, {7'h00, done});
        chk("busy with done", 8'h00, {7'h00, busy});
    endtask
    task automatic cmd(input logic [7:0] c, input logic [ADDR_W-1:0] a);
        run(OP_WRITE, 19'h00555, 8'hAA);
        run(OP_WRITE, 19'h002AA, 8'h55);
        run(OP_WRITE, a, c);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h41C5));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        chk("idle strobes", 8'h07, {5'h00, ce_n, oe_n, we_n});
        for (int k = 0; k < 6; k++) begin
            pa = 19'(($urandom % 8) << 16) | 19'(k);
            pd = 8'($urandom) & 8'hFE;
            lat <= 4'($urandom % 6);
            cmd(8'hA0, 19'h00555);
            run(OP_WRITE, pa, pd);
            run(k[0] ? OP_TOGGLE : OP_POLL, pa, pd);
            chk("program result", {6'h00, RES_OK}, {6'h00, result});
            chk("program data", pd, rdata);
            run(OP_READ, pa, 8'h00);
            chk("array read", pd, rdata);
            chk("raw result", {6'h00, RES_DATA}, {6'h00, result});
            $display("program test %0d ended", k);
        end
        for (int f = 0; f < 2; f++) begin
            lat <= 4'h2;
            cmd(8'hA0, 19'h00555);
            run(OP_WRITE, pa, 8'hFF);
            run(f ? OP_POLL : OP_TOGGLE, pa, 8'hFF);
            chk("fail result", {6'h00, RES_FAIL}, {6'h00, result});
            run(OP_READ, pa, 8'h00);
            chk("array after reset", pd, rdata);
            $display("failure test %0d ended", f);
        end
        lat <= 4'h4;
        cmd(8'h80, 19'h00555);
        cmd(8'h30, pa);
        run(OP_READ, pa, 8'h00);
        chk("window open", 8'h01, {7'h00, win});
        chk("erase poll bit", 8'h00, rdata & 8'h80);
        run(OP_POLL, pa, 8'hFF);
        chk("erase result", {6'h00, RES_OK}, {6'h00, result});
        chk("erased data", 8'hFF, rdata);
        $display("erase test ended");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule
